/* File: include/fpm_pkg.sv */
// Shared constants and types of the front panel menu controller.
// Assumes a single 10 MHz core clock; all slower rates derive from a 1 ms tick.
package fpm_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   localparam int DEB_MS = 10;
   localparam int TIMEOUT_MS = 12000;
   localparam int LAMP_MS = 1000;
   localparam int VER_MS = 1000;

   localparam int NSW = 5;
   localparam int SW_MENU = 0;
   localparam int SW_LEFT = 1;
   localparam int SW_RIGHT = 2;
   localparam int SW_UP = 3;
   localparam int SW_DOWN = 4;
   localparam int NPLL = 2;

   // Version code shown on the display; value is arbitrary
   localparam logic [7:0] FW_VERSION = 8'h10;

   localparam logic [11:0] FREQ_MIN = 12'h3b6;
   localparam logic [11:0] FREQ_MAX = 12'h5f5;
   localparam logic [11:0] LVL_MIN = 12'h00f;
   localparam logic [11:0] LVL_MAX = 12'h02d;
   localparam logic [11:0] GAIN_MIN = 12'h000;
   localparam logic [11:0] GAIN_MAX = 12'h032;
   localparam logic [11:0] ADDR_MAX = 12'h063;
   localparam logic [3:0][11:0] FREQ_STEP = {12'h001, 12'h00a, 12'h064, 12'h3e8};
   localparam logic [1:0][11:0] NUM_STEP = {12'h001, 12'h00a};
   localparam logic [2:0] RET_FREQ = 3'h4;
   localparam logic [2:0] RET_NUM = 3'h2;
   localparam logic [2:0] RET_OPT = 3'h1;
   localparam logic [2:0] CUR_YES = 3'h0;
   localparam logic [2:0] CUR_NO = 3'h1;

   typedef enum logic [3:0] {
      M_UPF, M_UPLVL, M_DNF, M_DNG, M_MUTE, M_REMOTE, M_SPEC,
      M_EXTREF, M_UPREF, M_DNREF, M_SERMODE, M_SERADDR, M_TEMP, M_CURR
   } fpm_menu_t;

   typedef enum logic [2:0] {ST_LAMP, ST_VER, ST_NORMAL, ST_MENU, ST_SAVE} fpm_state_t;

   // Input level is held as its magnitude: 6'd20 means minus 20
   typedef struct packed {
      logic [10:0] up_freq;
      logic [10:0] dn_freq;
      logic [5:0] up_lvl;
      logic [5:0] dn_gain;
      logic mute;
      logic remote;
      logic spec_inv;
      logic ext_ref;
      logic up_ref;
      logic dn_ref;
      logic ser_mode;
      logic [7:0] ser_addr;
   } fpm_set_t;

   localparam fpm_set_t SET_DEFAULT = '{
      up_freq: 11'h3b6, dn_freq: 11'h3b6, up_lvl: 6'h14, dn_gain: 6'h1e,
      mute: 1'b1, remote: 1'b0, spec_inv: 1'b0, ext_ref: 1'b0, up_ref: 1'b0,
      dn_ref: 1'b0, ser_mode: 1'b0, ser_addr: 8'h01};
endpackage

/* File: include/fpm_sw_if.sv */
// Carries the millisecond tick to the switch conditioner and its press events back.
// Both ends run on the core clock.
`timescale 1ns/1ns
interface fpm_sw_if #(parameter int N = 5);
   logic tick;
   logic [N-1:0] press;
   modport src (input tick, output press);
   modport dst (output tick, input press);
endinterface

/* File: rtl/fpm_debounce.sv */
// Switch conditioner: two-flop synchroniser, millisecond debounce, press pulse.
// Assumes raw switch levels are high while actuated and the tick is one cycle wide.
`timescale 1ns/1ns
module fpm_debounce #(
   parameter int N = 5,
   parameter int DEB_MS = 10
) (
   input wire logic i_core_clk,       // Core clock
   input wire logic i_rst,            // Synchronous reset
   input wire logic [N-1:0] i_sw_raw, // Raw switch levels
   fpm_sw_if.src sw                   // Tick in, presses out
);
   import fpm_pkg::*;
   localparam int CW = $clog2(DEB_MS + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(DEB_MS - 1);

   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] stable;
      logic [N-1:0][CW-1:0] cnt;
      logic [N-1:0] press;
   } fpm_deb_t;

   fpm_deb_t r_ff, nxt_r;

   always_comb begin
      nxt_r = r_ff;
      nxt_r.s1 = i_sw_raw;
      nxt_r.s2 = r_ff.s1;
      nxt_r.press = '0;
      for (int i = 0; i < N; i++) begin
         // A level must hold for the full window, so bounce yields one event
         if (r_ff.s2[i] == r_ff.stable[i]) begin
            nxt_r.cnt[i] = '0;
         end else if (sw.tick) begin
            if (r_ff.cnt[i] == CNT_LAST) begin
               nxt_r.cnt[i] = '0;
               nxt_r.stable[i] = r_ff.s2[i];
               nxt_r.press[i] = r_ff.s2[i];
            end else begin
               nxt_r.cnt[i] = r_ff.cnt[i] + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign sw.press = r_ff.press;

   a_single_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
      |sw.press |=> (sw.press & $past(sw.press)) == '0)
      else $error("press event lasted more than one cycle");
endmodule // fpm_debounce

/* File: rtl/fpm_menu_ctrl.sv */
// Front panel menu controller: boot display, menu walk, digit edit, save, timeout, alarm.
// Assumes storage outside returns the last saved set at power-up and keeps o_nv_data on write.
// Contract
// - Menus run up freq through views, then save.
// - Menu press opens; only confirmed save is permanent.
// - Twelve idle seconds discard edits, restore display.
// - Saved settings kept in non-volatile storage.
// - Boot shows segments, version, then frequencies.
// - Horizontal rocker moves cursor one place.
// - Vertical rocker steps the selected digit.
// - Vertical rocker inverts on/off items either way.
// - Frequency applied only after save is confirmed.
// - Level, gain live; stored only on save.
// - Menu press on return marker opens save.
// - Yes commits all; no restores all.
// - Menu press elsewhere advances to next item.
// - Input level limited minus 45 to minus 15.
// - Gain 0 to 50, steps of 1 or 10.
// - Alarm lamp lit while any loop unlocked.
// - Alarm relay signals alarm state outside.
`timescale 1ns/1ns
module fpm_menu_ctrl #(
   parameter int TICK_CYC = fpm_pkg::TICK_CYC,
   parameter int TIMEOUT_MS = fpm_pkg::TIMEOUT_MS,
   parameter int LAMP_MS = fpm_pkg::LAMP_MS,
   parameter int VER_MS = fpm_pkg::VER_MS,
   parameter int DEB_MS = fpm_pkg::DEB_MS
) (
   input wire logic i_core_clk,                   // Core clock
   input wire logic i_rst,                        // Synchronous reset
   input wire logic [fpm_pkg::NSW-1:0] i_sw_raw,  // Switch pins, high when actuated
   input wire logic [fpm_pkg::NPLL-1:0] i_pll_unlock, // Loop unlock pins
   input wire fpm_pkg::fpm_set_t i_nv_data,       // Stored settings
   input wire logic i_nv_valid,                   // Stored settings are valid
   output fpm_pkg::fpm_set_t o_nv_data,           // Settings to store
   output logic o_nv_wr,                          // Store strobe
   output fpm_pkg::fpm_state_t o_disp_state,      // Display screen
   output fpm_pkg::fpm_menu_t o_disp_menu,        // Menu shown
   output logic [2:0] o_disp_cursor,              // Cursor position
   output fpm_pkg::fpm_set_t o_disp_set,          // Values shown
   output logic o_disp_all_on,                    // All segments lit
   output logic [7:0] o_disp_version,             // Version code
   output logic [10:0] o_up_freq,                 // Up synthesizer MHz
   output logic [10:0] o_dn_freq,                 // Down synthesizer MHz
   output logic [5:0] o_up_level,                 // Up input level magnitude
   output logic [5:0] o_dn_gain,                  // Down gain
   output fpm_pkg::fpm_set_t o_applied,           // Saved option bits
   output logic o_alarm_lamp,                     // Alarm lamp
   output logic o_alarm_relay                     // Alarm relay coil
);
   import fpm_pkg::*;
   localparam int MW = $clog2(TIMEOUT_MS + 1);
   localparam int DW = $clog2(TICK_CYC + 1);
   localparam logic [MW-1:0] TO_LAST = MW'(TIMEOUT_MS - 1);
   localparam logic [MW-1:0] LAMP_LAST = MW'(LAMP_MS - 1);
   localparam logic [MW-1:0] VER_LAST = MW'(VER_MS - 1);
   localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYC - 1);

   typedef struct packed {
      fpm_state_t st;
      fpm_menu_t menu;
      logic [2:0] cur;
      logic [MW-1:0] ms;
      logic [DW-1:0] div;
      logic tick;
      logic loaded;
      fpm_set_t work;
      fpm_set_t saved;
      logic nv_wr;
      logic [NPLL-1:0] unl_s1;
      logic [NPLL-1:0] unl_s2;
      logic alarm;
      logic all_on;
   } fpm_ctl_t;

   fpm_ctl_t r_ff, nxt_r;
   fpm_sw_if #(.N(NSW)) sw ();

   fpm_debounce #(.N(NSW), .DEB_MS(DEB_MS)) u_deb (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_sw_raw(i_sw_raw),
      .sw(sw)
   );
   assign sw.tick = r_ff.tick;

   function automatic logic [2:0] ret_pos(input fpm_menu_t m);
      if (m == M_UPF || m == M_DNF) begin
         return RET_FREQ;
      end else if (m == M_UPLVL || m == M_DNG || m == M_SERADDR) begin
         return RET_NUM;
      end else begin
         return RET_OPT;
      end
   endfunction

   function automatic logic [11:0] step_of(input fpm_menu_t m, input logic [2:0] c);
      if (m == M_UPF || m == M_DNF) begin
         return FREQ_STEP[c[1:0]];
      end else begin
         return NUM_STEP[c[0]];
      end
   endfunction

   // Steps and clamps; going below or past a limit pins to that limit
   function automatic logic [11:0] adj(input logic [11:0] v, input logic [11:0] s,
                                       input logic up, input logic [11:0] lo,
                                       input logic [11:0] hi);
      logic [12:0] t;
      t = up ? {1'b0, v} + {1'b0, s} : {1'b0, v} - {1'b0, s};
      if (!up && (s > v || t[11:0] < lo)) begin
         return lo;
      end else if (t > {1'b0, hi}) begin
         return hi;
      end else begin
         return t[11:0];
      end
   endfunction

   logic ev_menu, ev_left, ev_right, ev_up, ev_dn, ev_any;
   logic [2:0] ret;
   logic [11:0] stp;
   assign ev_menu = sw.press[SW_MENU];
   assign ev_left = sw.press[SW_LEFT];
   assign ev_right = sw.press[SW_RIGHT];
   assign ev_up = sw.press[SW_UP];
   assign ev_dn = sw.press[SW_DOWN];
   assign ev_any = |sw.press;
   assign ret = ret_pos(r_ff.menu);
   assign stp = step_of(r_ff.menu, r_ff.cur);

   always_comb begin
      nxt_r = r_ff;
      nxt_r.nv_wr = 1'b0;
      nxt_r.tick = 1'b0;
      if (r_ff.div == DIV_LAST) begin
         nxt_r.div = '0;
         nxt_r.tick = 1'b1;
      end else begin
         nxt_r.div = r_ff.div + 1'b1;
      end
      nxt_r.unl_s1 = i_pll_unlock;
      nxt_r.unl_s2 = r_ff.unl_s1;
      nxt_r.alarm = |r_ff.unl_s2;
      case (r_ff.st)
         ST_LAMP: begin
            if (!r_ff.loaded) begin
               nxt_r.loaded = 1'b1;
               if (i_nv_valid) begin
                  nxt_r.saved = i_nv_data;
                  nxt_r.work = i_nv_data;
               end
            end
            if (r_ff.tick) begin
               nxt_r.ms = r_ff.ms + 1'b1;
               if (r_ff.ms == LAMP_LAST) begin
                  nxt_r.ms = '0;
                  nxt_r.st = ST_VER;
               end
            end
         end
         ST_VER: begin
            if (r_ff.tick) begin
               nxt_r.ms = r_ff.ms + 1'b1;
               if (r_ff.ms == VER_LAST) begin
                  nxt_r.ms = '0;
                  nxt_r.st = ST_NORMAL;
               end
            end
         end
         ST_NORMAL: begin
            if (ev_menu) begin
               nxt_r.st = ST_MENU;
               nxt_r.menu = M_UPF;
               nxt_r.cur = '0;
               nxt_r.ms = '0;
            end
         end
         ST_MENU: begin
            if (ev_menu) begin
               nxt_r.cur = '0;
               if (r_ff.cur == ret || r_ff.menu == M_CURR) begin
                  nxt_r.st = ST_SAVE;
               end else begin
                  nxt_r.menu = fpm_menu_t'(r_ff.menu + 4'h1);
               end
            end else if (ev_left) begin
               if (r_ff.cur != '0) nxt_r.cur = r_ff.cur - 1'b1;
            end else if (ev_right) begin
               if (r_ff.cur != ret) nxt_r.cur = r_ff.cur + 1'b1;
            end else if ((ev_up || ev_dn) && r_ff.cur != ret) begin
               // Frequency waits in work; level and gain reach the outputs from work
               case (r_ff.menu)
                  M_UPF: nxt_r.work.up_freq = 11'(adj(12'(r_ff.work.up_freq), stp,
                                                      ev_up, FREQ_MIN, FREQ_MAX));
                  M_DNF: nxt_r.work.dn_freq = 11'(adj(12'(r_ff.work.dn_freq), stp,
                                                      ev_up, FREQ_MIN, FREQ_MAX));
                  M_UPLVL: nxt_r.work.up_lvl = 6'(adj(12'(r_ff.work.up_lvl), stp,
                                                      ev_dn, LVL_MIN, LVL_MAX));
                  M_DNG: nxt_r.work.dn_gain = 6'(adj(12'(r_ff.work.dn_gain), stp,
                                                     ev_up, GAIN_MIN, GAIN_MAX));
                  M_SERADDR: nxt_r.work.ser_addr = 8'(adj(12'(r_ff.work.ser_addr), stp,
                                                          ev_up, GAIN_MIN, ADDR_MAX));
                  M_MUTE: nxt_r.work.mute = ~r_ff.work.mute;
                  M_REMOTE: nxt_r.work.remote = ~r_ff.work.remote;
                  M_SPEC: nxt_r.work.spec_inv = ~r_ff.work.spec_inv;
                  M_EXTREF: nxt_r.work.ext_ref = ~r_ff.work.ext_ref;
                  M_UPREF: nxt_r.work.up_ref = ~r_ff.work.up_ref;
                  M_DNREF: nxt_r.work.dn_ref = ~r_ff.work.dn_ref;
                  M_SERMODE: nxt_r.work.ser_mode = ~r_ff.work.ser_mode;
                  default: nxt_r.work = r_ff.work;
               endcase
            end
         end
         ST_SAVE: begin
            if (ev_menu) begin
               nxt_r.st = ST_NORMAL;
               nxt_r.cur = '0;
               if (r_ff.cur == CUR_YES) begin
                  nxt_r.saved = r_ff.work;
                  nxt_r.nv_wr = 1'b1;
               end else begin
                  nxt_r.work = r_ff.saved;
               end
            end else if (ev_left) begin
               nxt_r.cur = CUR_YES;
            end else if (ev_right) begin
               nxt_r.cur = CUR_NO;
            end
         end
         default: nxt_r.st = ST_NORMAL;
      endcase
      // Idle timer runs only while a session is open; any event restarts it
      if ((r_ff.st == ST_MENU || r_ff.st == ST_SAVE) && !ev_any) begin
         if (r_ff.tick) begin
            nxt_r.ms = r_ff.ms + 1'b1;
            if (r_ff.ms == TO_LAST) begin
               nxt_r.ms = '0;
               nxt_r.st = ST_NORMAL;
               nxt_r.cur = '0;
               nxt_r.work = r_ff.saved;
            end
         end
      end else if (r_ff.st == ST_MENU || r_ff.st == ST_SAVE) begin
         nxt_r.ms = '0;
      end
      nxt_r.all_on = (nxt_r.st == ST_LAMP);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         r_ff <= '0;
         r_ff.work <= SET_DEFAULT;
         r_ff.saved <= SET_DEFAULT;
         r_ff.all_on <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign o_nv_data = r_ff.saved;
   assign o_nv_wr = r_ff.nv_wr;
   assign o_disp_state = r_ff.st;
   assign o_disp_menu = r_ff.menu;
   assign o_disp_cursor = r_ff.cur;
   assign o_disp_set = r_ff.work;
   assign o_disp_all_on = r_ff.all_on;
   assign o_disp_version = FW_VERSION;
   assign o_up_freq = r_ff.saved.up_freq;
   assign o_dn_freq = r_ff.saved.dn_freq;
   assign o_up_level = r_ff.work.up_lvl;
   assign o_dn_gain = r_ff.work.dn_gain;
   assign o_applied = r_ff.saved;
   assign o_alarm_lamp = r_ff.alarm;
   assign o_alarm_relay = r_ff.alarm;

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   a_menu_advance: assert property (
      r_ff.st == ST_MENU && ev_menu && r_ff.cur != ret && r_ff.menu != M_CURR
      |=> r_ff.st == ST_MENU && r_ff.menu == fpm_menu_t'($past(r_ff.menu) + 4'h1))
      else $error("menu press did not advance one item");
   a_last_to_save: assert property (
      r_ff.st == ST_MENU && ev_menu && r_ff.menu == M_CURR |=> r_ff.st == ST_SAVE)
      else $error("last menu did not lead to save prompt");
   a_return_save: assert property (
      r_ff.st == ST_MENU && ev_menu && r_ff.cur == ret
      |=> r_ff.st == ST_SAVE && r_ff.cur == CUR_YES)
      else $error("return marker did not open save prompt");
   a_save_yes: assert property (
      r_ff.st == ST_SAVE && ev_menu && r_ff.cur == CUR_YES
      |=> r_ff.saved == $past(r_ff.work) && o_nv_wr ##1 !o_nv_wr)
      else $error("yes did not commit and store once");
   a_save_no: assert property (
      r_ff.st == ST_SAVE && ev_menu && r_ff.cur == CUR_NO
      |=> r_ff.work == $past(r_ff.saved) && !o_nv_wr)
      else $error("no did not restore settings");
   a_saved_hold: assert property (
      r_ff.loaded && !(r_ff.st == ST_SAVE && ev_menu) |=> $stable(r_ff.saved))
      else $error("settings committed without save");
   a_freq_wait: assert property (
      r_ff.st == ST_MENU && r_ff.menu == M_UPF && ev_up |=> $stable(o_up_freq))
      else $error("frequency applied before save");
   a_gain_live: assert property (
      r_ff.st == ST_MENU && r_ff.menu == M_DNG && r_ff.cur == 3'h0 && ev_up && !ev_menu
      && !ev_left && !ev_right && r_ff.work.dn_gain <= 6'h28
      |=> o_dn_gain == $past(o_dn_gain) + 6'h0a)
      else $error("gain ten step not applied at once");
   a_level_range: assert property (
      r_ff.loaded && r_ff.st != ST_LAMP |-> o_up_level >= 6'h0f && o_up_level <= 6'h2d)
      else $error("input level out of range");
   a_mute_toggle: assert property (
      r_ff.st == ST_MENU && r_ff.menu == M_MUTE && r_ff.cur == 3'h0 && ev_dn && !ev_menu
      && !ev_left && !ev_right |=> r_ff.work.mute != $past(r_ff.work.mute))
      else $error("mute did not invert");
   a_cursor_right: assert property (
      r_ff.st == ST_MENU && ev_right && !ev_menu && !ev_left && r_ff.cur < ret
      |=> r_ff.cur == $past(r_ff.cur) + 3'h1)
      else $error("cursor did not move right by one");
   a_idle_revert: assert property (
      r_ff.st == ST_MENU && r_ff.tick && r_ff.ms == TO_LAST && !ev_any
      |=> r_ff.st == ST_NORMAL && r_ff.work == $past(r_ff.saved))
      else $error("idle timeout did not restore");
   a_event_restart: assert property (
      r_ff.st == ST_MENU && ev_any && !ev_menu |=> r_ff.ms == '0)
      else $error("switch event did not restart timer");
   a_alarm_follow: assert property (
      |r_ff.unl_s2 |=> o_alarm_lamp && o_alarm_relay)
      else $error("alarm not raised on unlock");
   a_boot_order: assert property (
      r_ff.st == ST_VER |=> r_ff.st == ST_VER || r_ff.st == ST_NORMAL)
      else $error("boot screens out of order");

   c_boot_done: cover property (r_ff.st == ST_VER ##1 r_ff.st == ST_NORMAL);
   c_save_yes: cover property (r_ff.st == ST_SAVE && ev_menu && r_ff.cur == CUR_YES);
   c_save_no: cover property (r_ff.st == ST_SAVE && ev_menu && r_ff.cur == CUR_NO);
   c_timeout: cover property (r_ff.st == ST_MENU ##1 r_ff.st == ST_NORMAL && !$past(ev_any));
endmodule // fpm_menu_ctrl

/* File: bench/fpm_operator.sv */
// Operator model: actuates one front panel switch at a time.
// Assumes the hold covers the synchroniser plus the debounce window.
`timescale 1ns/1ns
module fpm_operator #(
   parameter int HOLD_CYC = 80
) (
   input wire logic i_core_clk,            // Core clock
   output logic [fpm_pkg::NSW-1:0] o_sw     // Switch levels, high while actuated
);
   initial o_sw = '0;
   // Release lasts as long as the hold, so each edge is seen cleanly
   task automatic press(input int idx);
      @(posedge i_core_clk);
      o_sw[idx] <= 1'b1;
      repeat (HOLD_CYC) @(posedge i_core_clk);
      o_sw[idx] <= 1'b0;
      repeat (HOLD_CYC) @(posedge i_core_clk);
   endtask
endmodule // fpm_operator

/* File: bench/fpm_menu_ctrl_tb.sv */
// Self-checking bench of the front panel menu controller.
// Assumes shortened counts: 10-cycle tick, 20 ms timeout, 3 ms boot screens.
`timescale 1ns/1ns
module fpm_menu_ctrl_tb;
   import fpm_pkg::*;
   logic clk = 1'b0;
   logic i_rst = 1'b1;
   logic [NSW-1:0] sw;
   logic [NPLL-1:0] unlock = '0;
   logic nv_valid = 1'b1;
   fpm_set_t nv, o_nv_data, o_disp_set, o_applied;
   logic o_nv_wr, o_disp_all_on, o_alarm_lamp, o_alarm_relay;
   fpm_state_t o_disp_state;
   fpm_menu_t o_disp_menu;
   logic [2:0] o_disp_cursor;
   logic [7:0] o_disp_version;
   logic [10:0] o_up_freq, o_dn_freq;
   logic [5:0] o_up_level, o_dn_gain;
   int bad_count = 0;
   int total_checks = 0;
   int wr_cnt = 0;
   always #50 clk = ~clk;
   initial begin
      nv = SET_DEFAULT;
      nv.up_freq = 11'h3e8;
      nv.dn_gain = 6'h14;
      nv.dn_freq = 11'h4b0;
   end
   fpm_operator op (.i_core_clk(clk), .o_sw(sw));
   fpm_menu_ctrl #(.TICK_CYC(10), .TIMEOUT_MS(20), .LAMP_MS(3), .VER_MS(3), .DEB_MS(2)) uut (
      .i_core_clk(clk), .i_rst(i_rst), .i_sw_raw(sw), .i_pll_unlock(unlock),
      .i_nv_data(nv), .i_nv_valid(nv_valid), .o_nv_data(o_nv_data), .o_nv_wr(o_nv_wr),
      .o_disp_state(o_disp_state), .o_disp_menu(o_disp_menu), .o_disp_cursor(o_disp_cursor),
      .o_disp_set(o_disp_set), .o_disp_all_on(o_disp_all_on), .o_disp_version(o_disp_version),
      .o_up_freq(o_up_freq), .o_dn_freq(o_dn_freq), .o_up_level(o_up_level),
      .o_dn_gain(o_dn_gain), .o_applied(o_applied), .o_alarm_lamp(o_alarm_lamp),
      .o_alarm_relay(o_alarm_relay));
   always @(posedge clk) if (o_nv_wr === 1'b1) wr_cnt <= wr_cnt + 1;
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Press, then look once the resulting update has landed
   task automatic tap(input int idx, input int n);
      repeat (n) op.press(idx);
      @(negedge clk);
   endtask
   task automatic wait_leave(input fpm_state_t s);
      for (int n = 0; n < 400 && o_disp_state === s; n++) @(negedge clk);
   endtask
   task automatic t_boot();
      @(negedge clk);
      chk("all_on", 16'h1, o_disp_all_on);
      chk("state", ST_LAMP, o_disp_state);
      wait_leave(ST_LAMP);
      chk("state", ST_VER, o_disp_state);
      chk("version", FW_VERSION, o_disp_version);
      wait_leave(ST_VER);
      chk("state", ST_NORMAL, o_disp_state);
      chk("up_freq", 16'h3e8, o_up_freq);
      chk("dn_freq", 16'h4b0, o_dn_freq);
      chk("dn_gain", 16'h14, o_dn_gain);
      $display("test boot done");
   endtask
   task automatic t_walk();
      int w;
      w = wr_cnt;
      tap(SW_MENU, 1);
      chk("state", ST_MENU, o_disp_state);
      chk("menu", M_UPF, o_disp_menu);
      for (int m = 1; m < 14; m++) begin
         tap(SW_MENU, 1);
         chk("menu", 16'(m), o_disp_menu);
      end
      tap(SW_MENU, 1);
      chk("state", ST_SAVE, o_disp_state);
      tap(SW_RIGHT, 1);
      chk("cursor", CUR_NO, o_disp_cursor);
      tap(SW_LEFT, 1);
      chk("cursor", CUR_YES, o_disp_cursor);
      tap(SW_RIGHT, 1);
      chk("cursor", CUR_NO, o_disp_cursor);
      tap(SW_MENU, 1);
      chk("state", ST_NORMAL, o_disp_state);
      chk("writes", 16'(w), 16'(wr_cnt));
      $display("test walk done");
   endtask
   task automatic t_freq();
      int w;
      w = wr_cnt;
      tap(SW_MENU, 1);
      tap(SW_UP, 1);
      chk("work_freq", 16'h5f5, o_disp_set.up_freq);
      chk("up_freq", 16'h3e8, o_up_freq);
      tap(SW_RIGHT, 4);
      chk("cursor", RET_FREQ, o_disp_cursor);
      tap(SW_LEFT, 1);
      chk("cursor", 16'h3, o_disp_cursor);
      tap(SW_RIGHT, 1);
      tap(SW_MENU, 1);
      chk("state", ST_SAVE, o_disp_state);
      chk("cursor", CUR_YES, o_disp_cursor);
      tap(SW_MENU, 1);
      chk("writes", 16'(w + 1), 16'(wr_cnt));
      chk("up_freq", 16'h5f5, o_up_freq);
      chk("nv_freq", 16'h5f5, o_nv_data.up_freq);
      $display("test freq done");
   endtask
   task automatic t_gain();
      int w;
      w = wr_cnt;
      tap(SW_MENU, 2);
      tap(SW_UP, 1);
      chk("up_level", 16'hf, o_up_level);
      tap(SW_DOWN, 4);
      chk("up_level", 16'h2d, o_up_level);
      tap(SW_MENU, 2);
      chk("menu", M_DNG, o_disp_menu);
      tap(SW_UP, 4);
      chk("dn_gain", 16'h32, o_dn_gain);
      tap(SW_RIGHT, 1);
      tap(SW_DOWN, 1);
      chk("dn_gain", 16'h31, o_dn_gain);
      wait_leave(ST_MENU);
      chk("state", ST_NORMAL, o_disp_state);
      chk("dn_gain", 16'h14, o_dn_gain);
      chk("up_level", 16'h14, o_up_level);
      chk("writes", 16'(w), 16'(wr_cnt));
      $display("test gain done");
   endtask
   task automatic t_mute();
      tap(SW_MENU, 5);
      tap(SW_UP, 1);
      chk("mute", 16'h0, o_disp_set.mute);
      tap(SW_DOWN, 1);
      chk("mute", 16'h1, o_disp_set.mute);
      tap(SW_DOWN, 1);
      chk("mute", 16'h0, o_disp_set.mute);
      chk("applied", 16'h1, o_applied.mute);
      tap(SW_RIGHT, 1);
      chk("cursor", RET_OPT, o_disp_cursor);
      tap(SW_MENU, 2);
      chk("applied", 16'h0, o_applied.mute);
      $display("test mute done");
   endtask
   task automatic t_alarm();
      @(posedge clk) unlock <= 2'b10;
      repeat (6) @(negedge clk);
      chk("lamp", 16'h1, o_alarm_lamp);
      chk("relay", 16'h1, o_alarm_relay);
      repeat (30) @(negedge clk);
      chk("lamp", 16'h1, o_alarm_lamp);
      @(posedge clk) unlock <= 2'b00;
      repeat (6) @(negedge clk);
      chk("lamp", 16'h0, o_alarm_lamp);
      chk("relay", 16'h0, o_alarm_relay);
      $display("test alarm done");
   endtask
   // Second reset with blank storage: the unit must fall back to its defaults
   task automatic t_blank();
      @(posedge clk);
      nv_valid <= 1'b0;
      i_rst <= 1'b1;
      repeat (12) @(posedge clk);
      i_rst <= 1'b0;
      @(negedge clk);
      chk("all_on", 16'h1, o_disp_all_on);
      chk("state", ST_LAMP, o_disp_state);
      wait_leave(ST_LAMP);
      wait_leave(ST_VER);
      chk("state", ST_NORMAL, o_disp_state);
      chk("up_freq", SET_DEFAULT.up_freq, o_up_freq);
      chk("dn_freq", SET_DEFAULT.dn_freq, o_dn_freq);
      chk("dn_gain", SET_DEFAULT.dn_gain, o_dn_gain);
      chk("applied", SET_DEFAULT.mute, o_applied.mute);
      $display("test blank done");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      i_rst <= 1'b0;
      t_boot();
      t_walk();
      t_freq();
      t_gain();
      t_mute();
      t_alarm();
      t_blank();
      wrap_up();
   end
   // Tests need about 9100 cycles; allow ample margin
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
endmodule // fpm_menu_ctrl_tb
